// ### src/lcie_pkg.sv
// Constants for the per-channel interrupt edge select and mask block
package lcie_pkg;

    // ********************************************************
    // Channel layout
    // ********************************************************
    localparam int LCIE_NUM_CH = 16;
    // Register index = block * 64 + offset; byte address = index * 4
    localparam logic [4:0] LCIE_CH0_BLOCK = 5'h1f;
    localparam logic [4:0] LCIE_LAST_BLOCK = 5'h0e;

    // ********************************************************
    // Register offsets inside one channel block (index units)
    // ********************************************************
    localparam logic [5:0] LCIE_OFF_EDGE_SEL = 6'h1a;
    localparam logic [5:0] LCIE_OFF_MASK_ZERO = 6'h1b;
    localparam logic [5:0] LCIE_OFF_MASK_ONE = 6'h1c;
    localparam logic [5:0] LCIE_OFF_STATUS_ZERO = 6'h1e;
    localparam logic [5:0] LCIE_OFF_STATUS_ONE = 6'h1f;
    localparam logic [5:0] LCIE_OFF_IRQ_STATUS_ZERO = 6'h20;
    localparam logic [5:0] LCIE_OFF_IRQ_STATUS_ONE = 6'h21;

    // ********************************************************
    // Reset values and implemented-bit masks
    // ********************************************************
    localparam logic [7:0] LCIE_EDGE_SEL_RST = 8'h00;
    localparam logic [7:0] LCIE_EDGE_SEL_IMPL = 8'h7f;
    localparam logic [7:0] LCIE_MASK_ZERO_RST = 8'hff;
    localparam logic [7:0] LCIE_MASK_ONE_RST = 8'he3;
    localparam logic [7:0] LCIE_MASK_ONE_IMPL = 8'he3;
    localparam logic [7:0] LCIE_ZERO_BYTE = 8'h00;

    // ********************************************************
    // Edge select field positions
    // ********************************************************
    localparam int LCIE_ES_ALARM = 6;
    localparam int LCIE_ES_PATTERN = 5;
    localparam int LCIE_ES_OVERCURRENT = 4;
    localparam int LCIE_ES_CLOCK_MISSING = 3;
    localparam int LCIE_ES_TX_LOSS = 2;
    localparam int LCIE_ES_RX_LOSS = 1;
    localparam int LCIE_ES_INBAND = 0;

endpackage : lcie_pkg

// ### src/lcie_top.sv
// Per-channel interrupt edge qualification, masking and Wishbone register file
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1 - Alarm statuses: rising only, or any change
// RULE2 - Pattern sync: rising only, or any change
// RULE3 - Overcurrent: rising only, or any change
// RULE4 - Clock missing: rising only, or any change
// RULE5 - Transmit loss: rising only, or any change
// RULE6 - Shared select for line/system receive loss
// RULE7 - Shared select for inband activate/deactivate
// RULE8 - Mask 0 passes, 1 blocks, reset 1
// RULE9 - Mask bit 7 gates waveform overflow
// RULE10 - Mask bit 6 gates transmit jitter FIFO
// RULE11 - Mask bit 5 gates receive jitter FIFO
// RULE12 - Mask bit 4 gates transmit overcurrent
// RULE13 - Mask bit 3 gates transmit clock missing
// RULE14 - Mask bit 2 gates transmit loss
// RULE15 - Mask bits 1/0 gate system/line loss
// RULE16 - Registers per channel, channel 0 high
// RULE17 - Edge select resets zero, bit 7 reserved
// RULE18 - Interrupt status latched until software clears
// RULE19 - Request when any unmasked status set
module lcie_top
    import lcie_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Per-channel status levels, bit n is channel n
    input wire logic [15:0] line_alarm_status_i,
    input wire logic [15:0] system_alarm_status_i,
    input wire logic [15:0] pattern_sync_status_i,
    input wire logic [15:0] overcurrent_status_i,
    input wire logic [15:0] clock_missing_status_i,
    input wire logic [15:0] tx_loss_status_i,
    input wire logic [15:0] line_loss_status_i,
    input wire logic [15:0] system_loss_status_i,
    input wire logic [15:0] inband_activate_status_i,
    input wire logic [15:0] inband_deactivate_status_i,
    // Per-channel event pulses, bit n is channel n
    input wire logic [15:0] waveform_overflow_i,
    input wire logic [15:0] tx_jitter_fifo_slip_i,
    input wire logic [15:0] rx_jitter_fifo_slip_i,
    // Interrupt request
    output logic irq_o
);

    // ********************************************************
    // Bus decode
    // ********************************************************
    logic ack_r;
    logic [31:0] dat_r;
    logic [7:0] rd_byte_nxt;

    wire logic [10:0] reg_index = wb_adr_i[12:2];
    wire logic [4:0] block_sel = reg_index[10:6];
    wire logic [5:0] reg_off = reg_index[5:0];
    wire logic upper_zero = (wb_adr_i[31:13] == 19'h00000);
    wire logic is_ch0 = (block_sel == LCIE_CH0_BLOCK);
    wire logic is_chn = (block_sel <= LCIE_LAST_BLOCK);
    // Channel 0 lives in the high block, the others follow block order
    wire logic [3:0] ch_sel = is_ch0 ? 4'h0 : (block_sel[3:0] + 4'h1); // RULE16
    wire logic ch_hit = upper_zero && (is_ch0 || is_chn); // RULE16
    wire logic bus_req = wb_cyc_i && wb_stb_i;
    // Writes land on the edge where the master sees ack
    wire logic wr_commit = bus_req && wb_we_i && ack_r && wb_sel_i[0] && ch_hit;
    wire logic [7:0] wr_byte = wb_dat_i[7:0];

    wire logic wr_edge_sel = wr_commit && (reg_off == LCIE_OFF_EDGE_SEL);
    wire logic wr_mask_zero = wr_commit && (reg_off == LCIE_OFF_MASK_ZERO);
    wire logic wr_mask_one = wr_commit && (reg_off == LCIE_OFF_MASK_ONE);
    wire logic wr_ists_zero = wr_commit && (reg_off == LCIE_OFF_IRQ_STATUS_ZERO);
    wire logic wr_ists_one = wr_commit && (reg_off == LCIE_OFF_IRQ_STATUS_ONE);

    // ********************************************************
    // Per-channel register storage
    // ********************************************************
    logic [7:0] edge_sel_r [LCIE_NUM_CH];
    logic [7:0] mask_zero_r [LCIE_NUM_CH];
    logic [7:0] mask_one_r [LCIE_NUM_CH];
    logic [7:0] ists_zero_r [LCIE_NUM_CH];
    logic [7:0] ists_one_r [LCIE_NUM_CH];
    logic [7:0] prev_zero_r [LCIE_NUM_CH];
    logic [7:0] prev_one_r [LCIE_NUM_CH];
    logic [7:0] stat_zero [LCIE_NUM_CH];
    logic [7:0] stat_one [LCIE_NUM_CH];
    logic [LCIE_NUM_CH-1:0] ch_irq;

    genvar ch;
    generate
        for (ch = 0; ch < LCIE_NUM_CH; ch = ch + 1)
        begin : g_ch
            logic [7:0] sel_zero;
            logic [7:0] sel_one;
            logic [7:0] set_zero;
            logic [7:0] set_one;
            logic [7:0] evt_zero;
            logic [7:0] ists_zero_nxt;
            logic [7:0] ists_one_nxt;
            logic ch_wr;

            // Raw status bytes, unused positions read zero
            assign stat_zero[ch] = {3'b000, overcurrent_status_i[ch],
                clock_missing_status_i[ch], tx_loss_status_i[ch],
                system_loss_status_i[ch], line_loss_status_i[ch]};
            assign stat_one[ch] = {system_alarm_status_i[ch], line_alarm_status_i[ch],
                pattern_sync_status_i[ch], 3'b000,
                inband_activate_status_i[ch], inband_deactivate_status_i[ch]};

            // Spread the shared select bits over the status bits they serve
            assign sel_zero = {3'b000,
                edge_sel_r[ch][LCIE_ES_OVERCURRENT], // RULE3
                edge_sel_r[ch][LCIE_ES_CLOCK_MISSING], // RULE4
                edge_sel_r[ch][LCIE_ES_TX_LOSS], // RULE5
                edge_sel_r[ch][LCIE_ES_RX_LOSS], // RULE6
                edge_sel_r[ch][LCIE_ES_RX_LOSS]}; // RULE6
            assign sel_one = {edge_sel_r[ch][LCIE_ES_ALARM], // RULE1
                edge_sel_r[ch][LCIE_ES_ALARM], // RULE1
                edge_sel_r[ch][LCIE_ES_PATTERN], // RULE2
                3'b000,
                edge_sel_r[ch][LCIE_ES_INBAND], // RULE7
                edge_sel_r[ch][LCIE_ES_INBAND]}; // RULE7

            // Select 0 takes rising changes only, select 1 takes either direction
            assign set_one = (sel_one & (stat_one[ch] ^ prev_one_r[ch]))
                | (~sel_one & stat_one[ch] & ~prev_one_r[ch]); // RULE1 RULE2 RULE7
            assign evt_zero = {waveform_overflow_i[ch], tx_jitter_fifo_slip_i[ch],
                rx_jitter_fifo_slip_i[ch], 5'b00000};
            assign set_zero = evt_zero | (sel_zero & (stat_zero[ch] ^ prev_zero_r[ch]))
                | (~sel_zero & stat_zero[ch] & ~prev_zero_r[ch]); // RULE3 RULE4 RULE5 RULE6

            // Write one to clear; a new event in the same cycle wins
            assign ch_wr = (ch_sel == 4'(ch));
            assign ists_zero_nxt = (ists_zero_r[ch]
                & ~((wr_ists_zero && ch_wr) ? wr_byte : LCIE_ZERO_BYTE)) | set_zero; // RULE18
            assign ists_one_nxt = (ists_one_r[ch]
                & ~((wr_ists_one && ch_wr) ? wr_byte & LCIE_MASK_ONE_IMPL : LCIE_ZERO_BYTE))
                | set_one; // RULE18

            // Mask bits 7..0 of mask zero gate the matching latched bits
            assign ch_irq[ch] = |(ists_zero_r[ch] & ~mask_zero_r[ch])
                | |(ists_one_r[ch] & ~mask_one_r[ch]); // RULE9 RULE10 RULE11 RULE12 RULE13 RULE14 RULE15

            // Configuration registers of this channel
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    edge_sel_r[ch] <= LCIE_EDGE_SEL_RST; // RULE17
                    mask_zero_r[ch] <= LCIE_MASK_ZERO_RST; // RULE8
                    mask_one_r[ch] <= LCIE_MASK_ONE_RST; // RULE8
                end
                else if (ch_wr)
                begin
                    if (wr_edge_sel)
                        edge_sel_r[ch] <= wr_byte & LCIE_EDGE_SEL_IMPL; // RULE17
                    if (wr_mask_zero)
                        mask_zero_r[ch] <= wr_byte; // RULE8
                    if (wr_mask_one)
                        mask_one_r[ch] <= wr_byte & LCIE_MASK_ONE_IMPL;
                end
            end

            // Edge history and latched interrupt status
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                begin
                    prev_zero_r[ch] <= LCIE_ZERO_BYTE;
                    prev_one_r[ch] <= LCIE_ZERO_BYTE;
                    ists_zero_r[ch] <= LCIE_ZERO_BYTE;
                    ists_one_r[ch] <= LCIE_ZERO_BYTE;
                end
                else
                begin
                    prev_zero_r[ch] <= stat_zero[ch];
                    prev_one_r[ch] <= stat_one[ch];
                    ists_zero_r[ch] <= ists_zero_nxt; // RULE18
                    ists_one_r[ch] <= ists_one_nxt; // RULE18
                end
            end
        end
    endgenerate

    // ********************************************************
    // Read data selection
    // ********************************************************
    // Unmapped addresses still answer, with zero data
    always_comb
    begin
        rd_byte_nxt = LCIE_ZERO_BYTE;
        if (ch_hit)
        begin
            if (reg_off == LCIE_OFF_EDGE_SEL)
                rd_byte_nxt = edge_sel_r[ch_sel]; // RULE17
            else if (reg_off == LCIE_OFF_MASK_ZERO)
                rd_byte_nxt = mask_zero_r[ch_sel];
            else if (reg_off == LCIE_OFF_MASK_ONE)
                rd_byte_nxt = mask_one_r[ch_sel];
            else if (reg_off == LCIE_OFF_STATUS_ZERO)
                rd_byte_nxt = stat_zero[ch_sel];
            else if (reg_off == LCIE_OFF_STATUS_ONE)
                rd_byte_nxt = stat_one[ch_sel];
            else if (reg_off == LCIE_OFF_IRQ_STATUS_ZERO)
                rd_byte_nxt = ists_zero_r[ch_sel];
            else if (reg_off == LCIE_OFF_IRQ_STATUS_ONE)
                rd_byte_nxt = ists_one_r[ch_sel];
        end
    end

    // ********************************************************
    // Bus handshake
    // ********************************************************
    // One wait state; ack drops the cycle after it is given
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_r <= 1'b0;
            dat_r <= 32'h00000000;
        end
        else
        begin
            ack_r <= bus_req && !ack_r;
            dat_r <= {24'h000000, rd_byte_nxt};
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = dat_r;
    // Level request from latched bits, so it holds until cleared or masked
    assign irq_o = |ch_irq; // RULE19

endmodule : lcie_top

`default_nettype wire

// ### tb/lcie_monitor.sv
// Bus and interrupt checker for the edge select and mask block
`timescale 1ns/1ps
`default_nettype none
module lcie_monitor
    import lcie_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Interrupt
    input wire logic irq_o
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic wrote_r;
    // Masks hold their reset value until the first committed write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            wrote_r <= 1'b0;
        else if (wb_ack_o && wb_we_i)
            wrote_r <= 1'b1;
    end
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ans; ##1 wb_ack_o ##1 !wb_ack_o; endsequence
    property p_walk; s_req |-> s_ans; endproperty
    property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    property p_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
    property p_upper; wb_ack_o |-> wb_dat_o[31:8] == 24'h0; endproperty
    property p_unmap; wb_ack_o && !wb_we_i && wb_adr_i[31:13] != 19'h0 |-> wb_dat_o == 32'h0;
    endproperty
    property p_quiet; !wrote_r |-> !irq_o; endproperty
    property p_sticky; $fell(irq_o) |-> $past(wb_ack_o && wb_we_i); endproperty
    a_walk: assert property (p_walk)
        else $error("ack not one cycle after request");
    a_pulse: assert property (p_pulse)
        else $error("ack longer than one cycle");
    a_cause: assert property (p_cause)
        else $error("ack without request");
    a_idle: assert property (p_idle)
        else $error("ack while idle");
    a_upper: assert property (p_upper)
        else $error("upper read bits not zero");
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    a_quiet: assert property (p_quiet)
        else $error("irq with reset masks");
    a_sticky: assert property (p_sticky)
        else $error("irq dropped without a write");
endmodule : lcie_monitor
bind lcie_top lcie_monitor lcie_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire

// ### tb/test_lcie_top.sv
// Directed testbench for the edge select and mask block
`timescale 1ns/1ps
`default_nettype none
module test_lcie_top
    import lcie_pkg::*;
;
    // ****************************************
    // Signals, tables and instance
    // ****************************************
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic irq_o;
    logic [15:0] st [10] = '{default: 16'h0};
    logic [15:0] ev [3] = '{default: 16'h0};
    logic [7:0] q;
    int error_cnt = 0;
    int compares = 0;
    // Per source: edge select bit, irq bit, upper irq byte
    int es_b [10] = '{6, 6, 5, 4, 3, 2, 1, 1, 0, 0};
    int is_b [10] = '{6, 7, 5, 4, 3, 2, 0, 1, 1, 0};
    logic [9:0] hi = 10'b1100000111;
    always #10 clk_i = ~clk_i;
    lcie_top lcie_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o,
        .line_alarm_status_i(st[0]), .system_alarm_status_i(st[1]),
        .pattern_sync_status_i(st[2]), .overcurrent_status_i(st[3]),
        .clock_missing_status_i(st[4]), .tx_loss_status_i(st[5]),
        .line_loss_status_i(st[6]), .system_loss_status_i(st[7]),
        .inband_activate_status_i(st[8]), .inband_deactivate_status_i(st[9]),
        .waveform_overflow_i(ev[0]), .tx_jitter_fifo_slip_i(ev[1]),
        .rx_jitter_fifo_slip_i(ev[2]));
    function automatic logic [31:0] ra(input int c, input logic [5:0] off);
        return {19'h0, (c == 0) ? LCIE_CH0_BLOCK : 5'(c - 1), off, 2'b00};
    endfunction : ra
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Classic cycle; no fixed latency assumed, bounded wait for ack
    task automatic wb(input logic we, input logic [31:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        do
            @(posedge clk_i);
        while (wb_ack_o !== 1'b1 && ++n < 50);
        q = wb_dat_o[7:0];
        if (n >= 50)
            chk("ack", 8'h1, 8'h0);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb
    task automatic rd(input string nm, input logic [31:0] a, input logic [7:0] exp);
        wb(1'b0, a, 8'h0);
        chk(nm, exp, q);
    endtask : rd
    // Sampled mid-cycle so the commit edge has landed
    task automatic irq(input logic exp);
        @(negedge clk_i);
        chk("irq", {7'h0, exp}, {7'h0, irq_o});
    endtask : irq
    task automatic set_st(input int i, input logic v);
        @(posedge clk_i);
        st[i][3] <= v;
    endtask : set_st
    // Reset values, channel copies, reserved bit, unmapped word
    task automatic t_regs();
        rd("es1", ra(1, LCIE_OFF_EDGE_SEL), 8'h00);
        rd("mask15", ra(15, LCIE_OFF_MASK_ZERO), 8'hff);
        wb(1'b1, ra(1, LCIE_OFF_EDGE_SEL), 8'hff);
        rd("es1 wr", ra(1, LCIE_OFF_EDGE_SEL), 8'h7f);
        rd("es0", ra(0, LCIE_OFF_EDGE_SEL), 8'h00);
        wb(1'b1, ra(0, LCIE_OFF_MASK_ZERO), 8'h5a);
        rd("mask0", ra(0, LCIE_OFF_MASK_ZERO), 8'h5a);
        rd("mask1", ra(1, LCIE_OFF_MASK_ZERO), 8'hff);
        wb(1'b1, 32'h0001_0000, 8'h5a);
        rd("unmapped", 32'h0001_0000, 8'h00);
    endtask : t_regs
    // Every status source: rising only, then both ways, then the mask
    task automatic t_edges();
        logic [31:0] ia;
        logic [7:0] m;
        for (int i = 0; i < 10; i++)
        begin
            ia = ra(3, hi[i] ? LCIE_OFF_IRQ_STATUS_ONE : LCIE_OFF_IRQ_STATUS_ZERO);
            m = 8'h1 << is_b[i];
            wb(1'b1, ra(3, LCIE_OFF_EDGE_SEL), 8'h00);
            set_st(i, 1'b1);
            rd("rise", ia, m);
            rd("raw", ia - 32'h8, m);
            wb(1'b1, ia, m);
            set_st(i, 1'b0);
            rd("fall", ia, 8'h00);
            wb(1'b1, ra(3, LCIE_OFF_EDGE_SEL), 8'h1 << es_b[i]);
            set_st(i, 1'b1);
            wb(1'b1, ia, m);
            set_st(i, 1'b0);
            rd("any", ia, m);
            irq(1'b0);
            wb(1'b1, ia - 32'h14, ~m);
            irq(1'b1);
            rd("held", ia, m);
            wb(1'b1, ia - 32'h14, 8'hff);
            wb(1'b1, ia, m);
            rd("clear", ia, 8'h00);
        end
    endtask : t_edges
    // One-cycle event pulses gated by mask bits 7 to 5
    task automatic t_events();
        logic [7:0] m;
        for (int j = 0; j < 3; j++)
        begin
            m = 8'h80 >> j;
            @(posedge clk_i);
            ev[j][3] <= 1'b1;
            @(posedge clk_i);
            ev[j][3] <= 1'b0;
            rd("event", ra(3, LCIE_OFF_IRQ_STATUS_ZERO), m);
            irq(1'b0);
            wb(1'b1, ra(3, LCIE_OFF_MASK_ZERO), ~m);
            irq(1'b1);
            wb(1'b1, ra(3, LCIE_OFF_MASK_ZERO), 8'hff);
            wb(1'b1, ra(3, LCIE_OFF_IRQ_STATUS_ZERO), m);
        end
    endtask : t_events
    task automatic results();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : results
    initial
    begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_edges();
        t_events();
        results();
    end
    // Watchdog far beyond the few hundred cycles needed
    initial
    begin
        #400000;
        error_cnt++;
        results();
    end
endmodule : test_lcie_top
`default_nettype wire
